// [hw/dss_top.sv]
// Purpose: selects the content of the three numeric displays
// Assumes: conditions and values come from logic on pclk; the key pin is asynchronous
// Notes:   registers over APB, zero wait states
`timescale 1ns/1ns
`include "dss_params.svh"
module dss_top #(
  parameter int HALF_SEC_CYC = `DSS_HALF_SEC_CYC
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // controller state
  input  wire logic                   has_third_display,
  input  wire logic                   heat_cool_active,
  input  wire logic                   input_is_temperature,
  input  wire dss_pkg::dss_cond_type  cond,
  input  wire dss_pkg::dss_values_type values,
  // function key pin, asynchronous
  input  wire logic                   fkey_pin,
  // display words
  output dss_pkg::dss_disp_type       disp1,
  output dss_pkg::dss_disp_type       disp2,
  output dss_pkg::dss_disp_type       disp3
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] ctrl;                 // heat/cool, fraction, status codes, interval
  logic [31:0] view;                 // display selections and key mode
  logic [31:0] items;                // five item codes
  logic        key_meta;             // synchroniser stage one
  logic        key_sync;             // synchroniser stage two
  logic        key_prev;             // for press detection
  logic [2:0]  item_idx;             // 0 normal view, 1..5 item shown
  logic        quarter_tick;         // quarter-second pulse
  logic [1:0]  quarter_count;        // quarters elapsed modulo four
  logic        phase;                // high during the tag slot
  logic        pri_active;           // primary tag condition holds
  logic        sec_active;           // second tag condition holds
  logic        refresh;              // monitor values may update now
  logic        hc_effective;         // heat/cool select is in force
  logic [4:0]  item_hit;             // per item: code is PV/SP/MV
  logic [4:0]  cur_item;             // code of the item on show
  logic [3:0]  sel1;
  logic [3:0]  sel2;
  logic        fkey_mode;
  logic        pv_first;             // first display shows the PV
  logic        sp_second;            // second display shows the SP
  logic        mv_third;             // third display shows the MV
  logic        alt_view;             // view allows the alternation
  logic        apb_setup;
  logic        apb_write;
  logic        mapped;
  dss_pkg::dss_values_type shown;    // values held for display
  dss_pkg::dss_refresh_type interval;
  dss_pkg::dss_disp_type next_disp1;
  dss_pkg::dss_disp_type next_disp2;
  dss_pkg::dss_disp_type next_disp3;

  assign sel1      = view[`DSS_VIEW_SEL1_LSB +: 4];
  assign sel2      = view[`DSS_VIEW_SEL2_LSB +: 4];
  assign fkey_mode = view[`DSS_VIEW_FKEY_BIT];
  assign interval  = dss_pkg::dss_refresh_type'(ctrl[`DSS_CTRL_INT_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode; always ready, unmapped offsets answer with an error
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite & mapped;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  always_comb
  begin
    mapped = 1'b0;
    unique case (paddr)
      `DSS_OFS_CTRL, `DSS_OFS_VIEW, `DSS_OFS_ITEMS: mapped = 1'b1;
      `DSS_OFS_STATUS:                              mapped = ~pwrite;
      default:                                      mapped = 1'b0;
    endcase
  end

  // control register; only implemented bits are kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `DSS_CTRL_RST;  // RQ3 RQ7 RQ12
    end
    else if (apb_write && paddr == `DSS_OFS_CTRL)
    begin
      ctrl <= {20'h00000, pwdata[11:0]};
    end
  end

  // view register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      view <= `DSS_VIEW_RST;
    end
    else if (apb_write && paddr == `DSS_OFS_VIEW)
    begin
      view <= {23'h000000, pwdata[8:0]};
    end
  end

  // item codes register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      items <= `DSS_ITEMS_RST;
    end
    else if (apb_write && paddr == `DSS_OFS_ITEMS)
    begin
      items <= {7'h00, pwdata[24:0]};
    end
  end

  // read data is captured in the setup cycle, held through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (apb_setup)
    begin
      unique case (paddr)
        `DSS_OFS_CTRL:   prdata <= ctrl;
        `DSS_OFS_VIEW:   prdata <= view;
        `DSS_OFS_ITEMS:  prdata <= items;
        `DSS_OFS_STATUS: prdata <= {25'h0000000, phase, item_idx, hc_effective, sec_active, pri_active};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // function key: two flops, then press detection on the settled copy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_meta <= 1'b0;
      key_sync <= 1'b0;
      key_prev <= 1'b0;
    end
    else
    begin
      key_meta <= fkey_pin;
      key_sync <= key_meta;
      key_prev <= key_sync;
    end
  end

  // each press steps items 1..5, then back to the normal view
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      item_idx <= 3'h0;
    end
    else if (!fkey_mode)
    begin
      item_idx <= 3'h0;  // leaving key mode drops back to normal view
    end
    else if (key_sync && !key_prev)
    begin
      item_idx <= (item_idx == 3'h5) ? 3'h0 : item_idx + 3'h1;  // RQ13
    end
  end

  // code of the item on show; zero in the normal view
  always_comb
  begin
    cur_item = 5'h00;
    if (item_idx != 3'h0)
    begin
      cur_item = items[(item_idx - 3'h1) * `DSS_ITEM_W +: `DSS_ITEM_W];  // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timebase and status decode
  dss_tick #(
    .HALF_CYC      (HALF_SEC_CYC)
  ) u_tick (
    .pclk          (pclk),
    .presetn       (presetn),
    .quarter_tick  (quarter_tick),
    .quarter_count (quarter_count),
    .phase         (phase)
  );

  dss_status_pick u_pri (
    .sel    (dss_pkg::dss_status_type'(ctrl[`DSS_CTRL_PRI_LSB +: 4])),
    .cond   (cond),
    .active (pri_active)
  );

  dss_status_pick u_sec (
    .sel    (dss_pkg::dss_status_type'(ctrl[`DSS_CTRL_SEC_LSB +: 4])),
    .cond   (cond),
    .active (sec_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // heat/cool select in force: in key mode, any of the five items set to PV/SP/MV counts
  for (genvar i = 0; i < 5; i++)
  begin : g_item
    assign item_hit[i] = items[i * `DSS_ITEM_W +: `DSS_ITEM_W] == `DSS_ITEM_PV_SP_MV;
  end

  assign hc_effective = has_third_display & heat_cool_active &
                        (sel1 == `DSS_SEL_PV_SP_MV | sel2 == `DSS_SEL_PV_SP_MV |
                         (fkey_mode & |item_hit));  // RQ2

  ////////////////////////////////////////////////////////////////////////////////
  // what the current view puts on each display
  always_comb
  begin
    pv_first  = 1'b0;
    sp_second = 1'b0;
    mv_third  = 1'b0;
    alt_view  = 1'b0;
    if (item_idx != 3'h0)
    begin
      // item view: PV/SP-type items show PV and SP
      unique case (cur_item)
        `DSS_ITEM_PV_SP_MSP, `DSS_ITEM_PV_SP_SK, `DSS_ITEM_PV_SP_ISP, `DSS_ITEM_PV_SP_AL1:
        begin
          pv_first  = 1'b1;
          sp_second = 1'b1;
          alt_view  = cur_item == `DSS_ITEM_PV_SP_MSP;  // RQ6
        end
        `DSS_ITEM_PV_SP_MV:
        begin
          pv_first  = 1'b1;
          sp_second = 1'b1;
          mv_third  = 1'b1;
        end
        default:
        begin
          pv_first  = 1'b0;
        end
      endcase
    end
    else
    begin
      pv_first  = sel1 != 4'h0 && sel1 != 4'h3 && sel1 <= 4'h8;
      sp_second = pv_first && sel1 != `DSS_SEL_PV;
      mv_third  = sel1 == `DSS_SEL_PV_SP_MV;
      alt_view  = sel1 == `DSS_SEL_PV || sel1 == `DSS_SEL_PV_SP ||
                  sel1 == `DSS_SEL_PV_SP_MV;  // RQ6
    end
    // manual control lets any view with PV on display 1 alternate
    if (cond.manual_mode && pv_first)
    begin
      alt_view = 1'b1;  // RQ6
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // refresh gate; only the displayed copy is slowed, control reads values directly
  always_comb
  begin
    refresh = 1'b1;
    unique case (interval)
      dss_pkg::DSS_RF_OFF:  refresh = 1'b1;  // RQ12
      dss_pkg::DSS_RF_Q:    refresh = quarter_tick;  // RQ12
      dss_pkg::DSS_RF_HALF: refresh = quarter_tick & quarter_count[0];  // RQ12
      dss_pkg::DSS_RF_ONE:  refresh = quarter_tick & (quarter_count == 2'h3);  // RQ12
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shown <= '0;
    end
    else if (refresh)
    begin
      shown <= values;  // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compose the three display words
  always_comb
  begin
    next_disp1             = '0;
    next_disp1.blank       = ~pv_first;
    next_disp1.value       = shown.pv;
    // decimals hidden only for temperature inputs with fraction show off
    next_disp1.frac_hidden = pv_first & input_is_temperature & ~ctrl[`DSS_CTRL_FRAC_BIT];  // RQ3 RQ4
    // tag in the phase slot while the condition holds, else steady value
    next_disp1.tag_on      = pv_first & alt_view & pri_active & phase;  // RQ5 RQ14
    next_disp1.tag         = ctrl[`DSS_CTRL_PRI_LSB +: 4];

    next_disp2             = '0;
    next_disp2.blank       = ~sp_second;
    next_disp2.value       = shown.sp;
    next_disp2.tag_on      = pv_first & alt_view & sec_active & phase;  // RQ10 RQ14
    next_disp2.tag         = ctrl[`DSS_CTRL_SEC_LSB +: 4];

    next_disp3             = '0;
    next_disp3.blank       = ~(has_third_display & mv_third);
    // cooling MV only when selected and in force; heating otherwise
    next_disp3.value       = (hc_effective & ctrl[`DSS_CTRL_HC_BIT]) ? shown.cool_mv : shown.heat_mv;  // RQ1 RQ2
  end

  // display words come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disp1 <= '0;
      disp2 <= '0;
      disp3 <= '0;
    end
    else
    begin
      disp1 <= next_disp1;
      disp2 <= next_disp2;
      disp3 <= next_disp3;
    end
  end

endmodule

// [hw/dss_params.svh]
// Purpose: constants for the display status selector (offsets, fields, resets, timing)
// Assumes: 32-bit APB register word, one aligned word per register
// Notes:   included by its bare name; definitions only
//
// Behaviour
// RQ1 - heat/cool select picks which MV shows
// RQ2 - select works only with third display, heat/cool, view
// RQ3 - fraction show OFF hides decimals; ON default
// RQ4 - decimal hiding only for temperature inputs
// RQ5 - first display alternates PV and tag, 0.5 s
// RQ6 - alternation only in PV-type views; in manual mode any view with PV on display 1 alternates
// RQ7 - each tag shows only while its condition holds
// RQ8 - any-alarm tag is OR of alarms 1-4
// RQ9 - heater tag on burnout or short alarm
// RQ10 - second display alternates likewise when PV first
// RQ11 - refresh interval slows display only, not control
// RQ12 - interval OFF, 0.25, 0.5, 1.0 s; 0.25 default
// RQ13 - function key steps items 1 to 5
// RQ14 - inactive condition means steady normal value
// RQ15 - phase from free-running half-second tick
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define DSS_OFS_CTRL       12'h000
`define DSS_OFS_VIEW       12'h004
`define DSS_OFS_ITEMS      12'h008
`define DSS_OFS_STATUS     12'h00C

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define DSS_CTRL_HC_BIT    0
`define DSS_CTRL_FRAC_BIT  1
`define DSS_CTRL_PRI_LSB   2
`define DSS_CTRL_SEC_LSB   6
`define DSS_CTRL_INT_LSB   10
`define DSS_CTRL_RST       32'h0000_0402

// view register fields
`define DSS_VIEW_SEL1_LSB  0
`define DSS_VIEW_SEL2_LSB  4
`define DSS_VIEW_FKEY_BIT  8
`define DSS_VIEW_RST       32'h0000_0004

// items register: five 5-bit item codes
`define DSS_ITEM_W         5
`define DSS_ITEMS_RST      32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// display selection and item codes
`define DSS_SEL_PV_SP      4'h1
`define DSS_SEL_PV         4'h2
`define DSS_SEL_PV_SP_MV   4'h4
`define DSS_ITEM_PV_SP_MSP 5'h01
`define DSS_ITEM_PV_SP_MV  5'h02
`define DSS_ITEM_PV_SP_SK  5'h03
`define DSS_ITEM_PV_SP_ISP 5'h13
`define DSS_ITEM_PV_SP_AL1 5'h14

////////////////////////////////////////////////////////////////////////////////
// timing
`define DSS_CLK_MHZ        125
`define DSS_HALF_SEC_MS    500
`define DSS_HALF_SEC_CYC   (`DSS_HALF_SEC_MS * `DSS_CLK_MHZ * 1000)

`endif

// [hw/dss_pkg.sv]
// Purpose: types shared by the display status selector files
// Assumes: constants live in dss_params.svh
// Notes:   nothing here is imported; users write dss_pkg::name
package dss_pkg;

  // status tag selection codes
  typedef enum logic [3:0] {
    DSS_ST_OFF    = 4'h0,
    DSS_ST_HAND   = 4'h1,
    DSS_ST_STOP   = 4'h2,
    DSS_ST_ALARM_ONE_TAG   = 4'h3,
    DSS_ST_ALM2   = 4'h4,
    DSS_ST_ALM3   = 4'h5,
    DSS_ST_ALM4   = 4'h6,
    DSS_ST_ANYALM = 4'h7,
    DSS_ST_HEATER = 4'h8
  } dss_status_type;

  // refresh interval codes
  typedef enum logic [1:0] {
    DSS_RF_OFF  = 2'h0,
    DSS_RF_Q    = 2'h1,
    DSS_RF_HALF = 2'h2,
    DSS_RF_ONE  = 2'h3
  } dss_refresh_type;

  // conditions from control and alarm logic
  typedef struct packed {
    logic       manual_mode;
    logic       stopped;
    logic [3:0] alarm;
    logic       heater_burnout_alarm;
    logic       heater_short_alarm;
  } dss_cond_type;

  // monitor values
  typedef struct packed {
    logic [15:0] pv;
    logic [15:0] sp;
    logic [15:0] heat_mv;
    logic [15:0] cool_mv;
  } dss_values_type;

  // one numeric display word
  typedef struct packed {
    logic        blank;
    logic        tag_on;
    logic [3:0]  tag;
    logic        frac_hidden;
    logic [15:0] value;
  } dss_disp_type;

endpackage

// [hw/dss_tick.sv]
// Purpose: free-running quarter-second tick and half-second phase
// Assumes: HALF_CYC is even and at least 2
// Notes:   runs from reset regardless of any setting
`timescale 1ns/1ns
module dss_tick #(
  parameter int HALF_CYC = 62500000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // tick outputs
  output logic      quarter_tick,
  output logic [1:0] quarter_count,
  output logic      phase
);

  localparam int QCYC = HALF_CYC / 2;
  localparam int CW   = $clog2(QCYC + 1);

  // refuse lengths the divider cannot serve
  if (HALF_CYC < 2 || (HALF_CYC % 2) != 0)
  begin : g_chk
    $error("dss_tick: HALF_CYC must be even and at least 2");
  end

  logic [CW-1:0] div_count;  // cycles within the quarter slot

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler: one pulse every quarter second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_count    <= '0;
      quarter_tick <= 1'b0;
    end
    else if (div_count == CW'(QCYC - 1))
    begin
      div_count    <= '0;
      quarter_tick <= 1'b1;
    end
    else
    begin
      div_count    <= div_count + CW'(1);
      quarter_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // quarter count; phase flips every two quarters, i.e. each 0.5 s
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quarter_count <= 2'h0;
    end
    else if (quarter_tick)
    begin
      quarter_count <= quarter_count + 2'h1;
    end
  end

  assign phase = quarter_count[1];  // RQ15

endmodule

// [hw/dss_status_pick.sv]
// Purpose: tells whether a selected status tag condition holds
// Assumes: conditions come from logic on the same clock
// Notes:   purely combinational
`timescale 1ns/1ns
module dss_status_pick (
  // selection and conditions
  input  wire dss_pkg::dss_status_type sel,
  input  wire dss_pkg::dss_cond_type   cond,
  // result
  output logic                         active
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode selection to its condition
  always_comb
  begin
    active = 1'b0;
    unique case (sel)
      dss_pkg::DSS_ST_OFF:    active = 1'b0;  // RQ7
      dss_pkg::DSS_ST_HAND:   active = cond.manual_mode;  // RQ7
      dss_pkg::DSS_ST_STOP:   active = cond.stopped;  // RQ7
      dss_pkg::DSS_ST_ALARM_ONE_TAG:   active = cond.alarm[0];  // RQ7
      dss_pkg::DSS_ST_ALM2:   active = cond.alarm[1];  // RQ7
      dss_pkg::DSS_ST_ALM3:   active = cond.alarm[2];  // RQ7
      dss_pkg::DSS_ST_ALM4:   active = cond.alarm[3];  // RQ7
      dss_pkg::DSS_ST_ANYALM: active = |cond.alarm;  // RQ8
      dss_pkg::DSS_ST_HEATER: active = cond.heater_burnout_alarm | cond.heater_short_alarm;  // RQ9
      // codes 9..15 written by software show no tag
      default:                active = 1'b0;
    endcase
  end

endmodule

// [sim/dss_chk.sv]
// Purpose: port-level checks of the display status selector
// Assumes: the tag field carries the selected status code
// Notes:   bound to dss_top; one clock domain
`timescale 1ns/1ns
module dss_chk #(
  parameter int HALF_SEC_CYC = 8
) (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb handshake
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // controller state
  input wire logic                   input_is_temperature,
  input wire dss_pkg::dss_cond_type  cond,
  // display words
  input wire dss_pkg::dss_disp_type  disp1,
  input wire dss_pkg::dss_disp_type  disp2
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  int unsigned run1;  // consecutive cycles with a tag lit on display 1

  // a tag slot longer than half a second means the phase is stuck
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run1 <= 0;
    else if (disp1.tag_on)
      run1 <= run1 + 1;
    else
      run1 <= 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_hand_cause: assert property (disp1.tag_on && disp1.tag == 4'h1 |-> $past(cond.manual_mode))
    else $error("hand tag without manual");
  a_stop_cause: assert property (disp1.tag_on && disp1.tag == 4'h2 |-> $past(cond.stopped))
    else $error("stop tag while running");
  a_alarm_cause: assert property (disp1.tag_on && disp1.tag inside {[4'h3:4'h6]}
    |-> |($past(cond.alarm) & (4'h1 << (disp1.tag - 4'h3))))
    else $error("alarm tag without alarm");
  a_any_alarm: assert property (disp2.tag_on && disp2.tag == 4'h7 |-> |$past(cond.alarm))
    else $error("any-alarm tag with no alarm");
  a_heater_cause: assert property (disp1.tag_on && disp1.tag == 4'h8
    |-> $past(cond.heater_burnout_alarm | cond.heater_short_alarm))
    else $error("heater tag without heater alarm");
  a_frac_temp: assert property (disp1.frac_hidden |-> $past(input_is_temperature))
    else $error("decimals hidden on analog input");
  a_tag_half_slot: assert property (run1 <= HALF_SEC_CYC)
    else $error("tag slot longer than half second");
  a_tag_off_code: assert property (disp1.tag_on |-> disp1.tag inside {[4'h1:4'h8]})
    else $error("tag lit for a no-tag code");

  // main scenarios
  c_tag_lit: cover property (disp1.tag_on && disp2.tag_on);
  c_slverr: cover property (pslverr);
  c_frac: cover property (disp1.frac_hidden);
endmodule

bind dss_top dss_chk #(.HALF_SEC_CYC(HALF_SEC_CYC)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .input_is_temperature(input_is_temperature), .cond(cond),
  .disp1(disp1), .disp2(disp2)
);

// [sim/dss_panel.sv]
// Purpose: front-panel digit row model, tallies lit tag slots
// Assumes: display words are registered on pclk
// Notes:   a blank row lights nothing, even with tag_on set
`timescale 1ns/1ns
module dss_panel (
  // clock and tally control
  input  wire logic                  pclk,
  input  wire logic                  clear,
  // display words
  input  wire dss_pkg::dss_disp_type disp1,
  input  wire dss_pkg::dss_disp_type disp2,
  // slots that showed a tag
  output int unsigned                tags1,
  output int unsigned                tags2
);
  // count a slot only when the row really lights the tag
  always_ff @(posedge pclk)
  begin
    if (clear)
    begin
      tags1 <= 0;
      tags2 <= 0;
    end
    else
    begin
      tags1 <= tags1 + 32'(disp1.tag_on & ~disp1.blank);
      tags2 <= tags2 + 32'(disp2.tag_on & ~disp2.blank);
    end
  end
endmodule

// [sim/dss_top_bench.sv]
// Purpose: self-checking bench of the display status selector
// Assumes: half second shortened to 8 cycles
// Notes:   values.pv counts every cycle so refresh rates show
`timescale 1ns/1ns
`include "dss_params.svh"
module dss_top_bench;
  logic                    pclk, presetn, psel, penable, pwrite, fkey_pin, clear;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic                    pready, pslverr, has_third, hc_act, is_temp;
  dss_pkg::dss_cond_type   cond;
  dss_pkg::dss_values_type values;
  dss_pkg::dss_disp_type   disp1, disp2, disp3;
  int unsigned             tags1, tags2, n, n_errors, check_count;
  logic [15:0]             prev;

  dss_top #(.HALF_SEC_CYC(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .has_third_display(has_third), .heat_cool_active(hc_act), .input_is_temperature(is_temp),
    .cond(cond), .values(values), .fkey_pin(fkey_pin), .disp1(disp1), .disp2(disp2), .disp3(disp3));
  dss_panel i_panel (.pclk(pclk), .clear(clear), .disp1(disp1), .disp2(disp2), .tags1(tags1), .tags2(tags2));

  // 125 MHz clock
  always #4 pclk = ~pclk;
  // moving process value
  always @(posedge pclk)
    values.pv <= values.pv + 16'h1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic err);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge pclk);
    end
    if (k == 20)
    begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic err;
    apb(1'b1, a, d, err);
    check(err, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input logic e);
    logic err;
    apb(1'b0, a, 32'h0, err);
    check(err, e);
    check(rd & m, x);
  endtask

  // tag slots lit over 32 cycles, two full phase periods
  task automatic tally;
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (32) @(posedge pclk);
    #1;
    n = tags1;
    @(posedge pclk);
  endtask

  function automatic dss_pkg::dss_cond_type cond_for(int c);
    dss_pkg::dss_cond_type r;
    r = '0;
    case (c)
      1: r.manual_mode = 1'b1;
      2: r.stopped = 1'b1;
      7: r.alarm = 4'h8;  // alarm 4 alone must still raise the any-alarm tag
      8: r.heater_short_alarm = 1'b1;
      default: r.alarm[c - 3] = 1'b1;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, fkey_pin, clear, is_temp} = '0;
    {has_third, hc_act} = 2'b11;
    paddr = 12'h000;
    pwdata = 32'h0;
    cond = '0;
    values = '0;
    values.heat_mv = 16'h1111;
    values.cool_mv = 16'h2222;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, refusals, read-back
    rdchk(`DSS_OFS_CTRL, 32'hFFFF_FFFF, `DSS_CTRL_RST, 1'b0);
    rdchk(`DSS_OFS_VIEW, 32'hFFFF_FFFF, `DSS_VIEW_RST, 1'b0);
    rdchk(`DSS_OFS_ITEMS, 32'hFFFF_FFFF, `DSS_ITEMS_RST, 1'b0);
    rdchk(12'h010, 32'hFFFF_FFFF, 32'h0, 1'b1);
    wr(`DSS_OFS_STATUS, 32'hFFFF_FFFF, 1'b1);
    wr(`DSS_OFS_CTRL, 32'hFFFF_FFFF, 1'b0);
    rdchk(`DSS_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0FFF, 1'b0);
    // heating or cooling value on display 3
    wr(`DSS_OFS_CTRL, 32'h2, 1'b0);
    repeat (4) @(posedge pclk);
    check(disp3.value, 32'h1111);
    check(disp3.blank, 1'b0);
    wr(`DSS_OFS_CTRL, 32'h3, 1'b0);
    repeat (4) @(posedge pclk);
    check(disp3.value, 32'h2222);
    rdchk(`DSS_OFS_STATUS, 32'h4, 32'h4, 1'b0);
    hc_act <= 1'b0;
    repeat (4) @(posedge pclk);
    check(disp3.value, 32'h1111);
    rdchk(`DSS_OFS_STATUS, 32'h4, 32'h0, 1'b0);
    hc_act <= 1'b1;
    // decimal hiding
    is_temp <= 1'b1;
    wr(`DSS_OFS_CTRL, 32'h0, 1'b0);
    @(posedge pclk);
    check(disp1.frac_hidden, 1'b1);
    is_temp <= 1'b0;
    repeat (3) @(posedge pclk);
    check(disp1.frac_hidden, 1'b0);
    is_temp <= 1'b1;
    wr(`DSS_OFS_CTRL, 32'h2, 1'b0);
    @(posedge pclk);
    check(disp1.frac_hidden, 1'b0);
    // status codes 1 to 8 on both lines, condition held then dropped
    for (int c = 1; c <= 8; c++)
    begin
      wr(`DSS_OFS_CTRL, 32'(c << 2 | c << 6 | 2), 1'b0);
      cond <= cond_for(c);
      tally();
      check(n, 16);
      check(tags2, 16);
      cond <= '0;
      tally();
      check(n + tags2, 0);
    end
    // set point on display 1 never alternates
    cond <= cond_for(8);
    wr(`DSS_OFS_VIEW, 32'h3, 1'b0);
    tally();
    check(n + tags2, 0);
    check(disp1.blank, 1'b1);
    cond <= '0;
    wr(`DSS_OFS_VIEW, 32'h4, 1'b0);
    // refresh interval OFF, 0.25, 0.5, 1.0 s
    for (int i = 0; i < 4; i++)
    begin
      wr(`DSS_OFS_CTRL, 32'(i << 10 | 2), 1'b0);
      repeat (16) @(posedge pclk);
      n = 0;
      prev = disp1.value;
      repeat (64)
      begin
        @(posedge pclk);
        if (disp1.value !== prev)
          n++;
        prev = disp1.value;
      end
      check(n, (i == 0) ? 64 : 64 >> (i + 1));
    end
    // key item stepping, items 1,2,3,19,20
    wr(`DSS_OFS_ITEMS, 32'h0149_8C41, 1'b0);
    wr(`DSS_OFS_VIEW, 32'h100, 1'b0);
    rdchk(`DSS_OFS_STATUS, 32'h4, 32'h4, 1'b0);
    for (int k = 1; k <= 6; k++)
    begin
      fkey_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      fkey_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      rdchk(`DSS_OFS_STATUS, 32'h38, 32'((k % 6) << 3), 1'b0);
    end
    end_of_test();
  end
endmodule
